// ---- logic/wdt_pkg.sv ----
// package: register map, field layout and constants of the windowed watchdog
package wdt_pkg;
    localparam logic [7:0]  OFS_COMMAND     = 8'h00;
    localparam logic [7:0]  OFS_SETUP       = 8'h04;
    localparam logic [7:0]  OFS_FAULT_FLAGS = 8'h08;

    localparam logic [7:0]  COMMAND_KEY     = 8'hA5;
    localparam int          KEY_LSB         = 24;
    localparam int          RESTART_BIT     = 0;

    localparam logic [31:0] SETUP_RESET     = 32'h3FFF_2FFF;
    localparam int          RELOAD_LSB      = 0;
    localparam int          FAULT_IRQ_BIT   = 12;
    localparam int          RESET_EN_BIT    = 13;
    localparam int          PROC_ONLY_BIT   = 14;
    localparam int          DISABLE_BIT     = 15;
    localparam int          DELTA_LSB       = 16;
    localparam int          DEBUG_HALT_BIT  = 28;
    localparam int          IDLE_HALT_BIT   = 29;

    localparam int          UNDERFLOW_BIT   = 0;
    localparam int          WINDOW_ERR_BIT  = 1;

    localparam int          COUNT_WIDTH     = 12;
    localparam int          PRESCALE_DIV    = 128;

    typedef struct packed {
        logic                   idleHalt;
        logic                   debugHalt;
        logic [COUNT_WIDTH-1:0] restartWindowDelta;
        logic                   timerDisable;
        logic                   processorResetOnly;
        logic                   faultResetEnable;
        logic                   faultIrqEnable;
        logic [COUNT_WIDTH-1:0] reloadValue;
    } setup_s;

    typedef struct packed {
        logic faultReset;
        logic faultResetAll;
        logic faultResetProc;
        logic faultIrq;
    } fault_out_s;
endpackage : wdt_pkg

// ---- logic/wdt_prescaler.sv ----
// prescaler: slow clock enable divided down to one watchdog tick
`timescale 1ns/1ps
module wdt_prescaler #(
    parameter int DIV = 128
) (
    input  wire logic sys_clk,
    input  wire logic reset_n,
    input  wire logic slowTick,
    input  wire logic restart,
    input  wire logic run,
    output logic      tick
);
    localparam int W = $clog2(DIV);
    localparam logic [W-1:0] LAST = W'(DIV - 1);

    logic [W-1:0] count;
    logic [W-1:0] next_count;
    logic         next_tick;

    always_comb begin
        next_count = count;
        next_tick  = 1'b0;
        if (restart) begin
            next_count = '0;
        end else if (run && slowTick) begin
            if (count == LAST) begin
                next_count = '0;
                next_tick  = 1'b1;
            end else begin
                next_count = count + W'(1);
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            count <= '0;
            tick  <= 1'b0;
        end else begin
            count <= next_count;
            tick  <= next_tick;
        end
    end
endmodule : wdt_prescaler

// ---- logic/windowed_watchdog_timer.sv ----
// windowed watchdog timer with APB register slave
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
module windowed_watchdog_timer #(
    parameter int COUNT_WIDTH  = wdt_pkg::COUNT_WIDTH,
    parameter int PRESCALE_DIV = wdt_pkg::PRESCALE_DIV
) (
    input  wire logic               sys_clk,
    input  wire logic               reset_n,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire logic               slowTick,
    input  wire logic               debugState,
    input  wire logic               idleState,
    output wdt_pkg::fault_out_s     faultOut
);
    wdt_pkg::setup_s        setup;
    wdt_pkg::setup_s        next_setup;
    logic                   setupLocked;
    logic                   next_setupLocked;
    logic [COUNT_WIDTH-1:0] counter;
    logic [COUNT_WIDTH-1:0] next_counter;
    logic                   underflowFlag;
    logic                   next_underflowFlag;
    logic                   windowErrorFlag;
    logic                   next_windowErrorFlag;
    logic                   faultIrq;
    logic                   next_faultIrq;
    logic                   faultLine;
    logic                   next_faultLine;
    logic                   faultProcOnly;
    logic                   next_faultProcOnly;
    logic [31:0]            next_prdata;
    logic                   tick;

    function automatic logic hit(input logic [7:0] a,
                                 input logic [7:0] ofs);
        hit = (a[7:2] == ofs[7:2]);
    endfunction : hit

    logic access;
    logic wrCommand;
    logic wrSetup;
    logic rdFlags;
    logic keyOk;
    logic restartCmd;
    logic inWindow;
    logic restartOk;
    logic windowErr;
    logic running;
    logic underflow;
    logic setupWrite;

    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign access  = psel && penable;
    assign wrCommand = access && pwrite && hit(paddr, wdt_pkg::OFS_COMMAND);
    assign wrSetup   = access && pwrite && hit(paddr, wdt_pkg::OFS_SETUP);
    assign rdFlags   = access && !pwrite
                       && hit(paddr, wdt_pkg::OFS_FAULT_FLAGS);
    assign keyOk = (pwdata[wdt_pkg::KEY_LSB +: 8] == wdt_pkg::COMMAND_KEY);
    assign restartCmd = wrCommand && keyOk
                        && pwdata[wdt_pkg::RESTART_BIT];
    assign inWindow  = (counter <= setup.restartWindowDelta);
    assign restartOk = restartCmd && inWindow;
    // error is raised even while disabled, as the window check is independent
    assign windowErr = restartCmd && !inWindow;
    assign setupWrite = wrSetup && !setupLocked;
    assign running = !setup.timerDisable
                     && !(setup.debugHalt && debugState)
                     && !(setup.idleHalt && idleState);
    assign underflow = running && tick && (counter == '0);

    wdt_prescaler #(
        .DIV     (PRESCALE_DIV)
    ) u_prescaler (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .slowTick(slowTick),
        .restart (restartOk || setupWrite),
        .run     (running),
        .tick    (tick)
    );

    always_comb begin
        next_setup       = setup;
        next_setupLocked = setupLocked;
        if (setupWrite) begin
            // the setup struct covers bits 29:0; bits 31:30 are not kept
            next_setup       = wdt_pkg::setup_s'(pwdata[29:0]);
            next_setupLocked = 1'b1;
        end
    end

    always_comb begin
        next_counter = counter;
        if (setupWrite) begin
            next_counter = pwdata[wdt_pkg::RELOAD_LSB +: COUNT_WIDTH];
        end else if (restartOk) begin
            next_counter = setup.reloadValue;
        end else if (running && tick) begin
            // underflow wraps back to the reload value and keeps going
            next_counter = (counter == '0) ? setup.reloadValue
                                           : counter - COUNT_WIDTH'(1);
        end
    end

    always_comb begin
        logic newFault;
        newFault = underflow || windowErr;
        next_underflowFlag   = underflowFlag;
        next_windowErrorFlag = windowErrorFlag;
        next_faultIrq        = faultIrq;
        next_faultLine       = faultLine;
        next_faultProcOnly   = faultProcOnly;
        if (rdFlags) begin
            next_underflowFlag   = 1'b0;
            next_windowErrorFlag = 1'b0;
            next_faultIrq        = 1'b0;
            next_faultLine       = 1'b0;
        end
        // a fault in the read cycle survives the clear
        if (underflow) begin
            next_underflowFlag = 1'b1;
        end
        if (windowErr) begin
            next_windowErrorFlag = 1'b1;
        end
        if (newFault && setup.faultIrqEnable) begin
            next_faultIrq = 1'b1;
        end
        if (newFault && setup.faultResetEnable) begin
            next_faultLine     = 1'b1;
            next_faultProcOnly = setup.processorResetOnly;
        end
    end

    always_comb begin
        next_prdata = 32'h0000_0000;
        if (psel && !penable && !pwrite) begin
            if (hit(paddr, wdt_pkg::OFS_SETUP)) begin
                next_prdata = 32'(setup);
            end else if (hit(paddr, wdt_pkg::OFS_FAULT_FLAGS)) begin
                next_prdata[wdt_pkg::UNDERFLOW_BIT]  = underflowFlag;
                next_prdata[wdt_pkg::WINDOW_ERR_BIT] = windowErrorFlag;
            end
        end else if (access) begin
            next_prdata = prdata;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            setup           <= wdt_pkg::setup_s'(wdt_pkg::SETUP_RESET[29:0]);
            setupLocked     <= 1'b0;
            counter         <= wdt_pkg::SETUP_RESET[COUNT_WIDTH-1:0];
            underflowFlag   <= 1'b0;
            windowErrorFlag <= 1'b0;
            faultIrq        <= 1'b0;
            faultLine       <= 1'b0;
            faultProcOnly   <= 1'b0;
            prdata          <= 32'h0000_0000;
        end else begin
            setup           <= next_setup;
            setupLocked     <= next_setupLocked;
            counter         <= next_counter;
            underflowFlag   <= next_underflowFlag;
            windowErrorFlag <= next_windowErrorFlag;
            faultIrq        <= next_faultIrq;
            faultLine       <= next_faultLine;
            faultProcOnly   <= next_faultProcOnly;
            prdata          <= next_prdata;
        end
    end

    always_comb begin
        faultOut.faultIrq       = faultIrq;
        faultOut.faultReset     = faultLine;
        faultOut.faultResetAll  = faultLine && !faultProcOnly;
        faultOut.faultResetProc = faultLine;
    end

    setup_once_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        setupLocked && wrSetup |=> $stable(setup))
        else $error("setup changed after lock");
    bad_key_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        wrCommand && !keyOk && !tick && !underflow && !rdFlags
        |=> $stable(counter) && $stable(windowErrorFlag))
        else $error("bad key write had effect");
    reload_ok_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        restartOk && !setupWrite |=> counter == $past(setup.reloadValue))
        else $error("restart did not reload");
    window_err_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        windowErr |=> windowErrorFlag)
        else $error("window error not flagged");
    underflow_flag_a: assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        underflow |=> underflowFlag ##0 (faultLine == $past(setup.faultResetEnable)
            || $past(faultLine)))
        else $error("underflow not flagged");
    read_clear_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        rdFlags && !underflow && !windowErr
        |=> !underflowFlag && !windowErrorFlag && !faultIrq)
        else $error("status read did not clear");
    halt_hold_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        !running && !restartOk && !setupWrite |=> $stable(counter))
        else $error("counter moved while halted");
    irq_gate_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        !setup.faultIrqEnable && !faultIrq && !setupWrite
        |=> !faultIrq)
        else $error("irq raised while masked");
    scope_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        faultOut.faultResetAll |-> faultLine && !faultProcOnly)
        else $error("reset scope wrong");

    restart_cover: cover property (@(posedge sys_clk) restartOk);
    error_cover: cover property (@(posedge sys_clk) windowErr);
    underflow_cover: cover property (@(posedge sys_clk) underflow);
    clear_cover: cover property (@(posedge sys_clk) rdFlags && underflowFlag);
endmodule : windowed_watchdog_timer

// ---- sim/wdt_far_side.sv ----
// far side model: slow clock enable source and reset controller monitor
`timescale 1ns/1ps
module wdt_far_side #(
    parameter int SLOW_DIV = 2
) (
    input  wire logic               sys_clk,
    input  wire logic               reset_n,
    input  wire logic               clearSeen,
    input  wdt_pkg::fault_out_s     faultOut,
    output logic                    slowTick,
    output logic                    resetAllSeen,
    output logic                    resetProcSeen
);
    int slowCount;

    // slow clock stands in as a one-cycle enable, never stopped
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            slowCount     <= 0;
            slowTick      <= 1'b0;
            resetAllSeen  <= 1'b0;
            resetProcSeen <= 1'b0;
        end else begin
            slowCount <= (slowCount == SLOW_DIV - 1) ? 0 : slowCount + 1;
            slowTick  <= (slowCount == SLOW_DIV - 1);
            // the controller latches which scope was requested since the last clearSeen
            if (clearSeen) begin
                resetAllSeen  <= 1'b0;
                resetProcSeen <= 1'b0;
            end else begin
                resetAllSeen  <= resetAllSeen | faultOut.faultResetAll;
                resetProcSeen <= resetProcSeen | faultOut.faultResetProc;
            end
        end
    end
endmodule : wdt_far_side

// ---- sim/tb_top.sv ----
// self-checking bench for the windowed watchdog over APB
`timescale 1ns/1ps
module tb_top;
    logic sys_clk, reset_n, psel, penable, pwrite, debugState, idleState;
    logic clearSeen, slowTick, resetAllSeen, resetProcSeen;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic        pready, pslverr;
    wdt_pkg::fault_out_s faultOut;
    int err_count, samples_checked, cycles;
    logic [31:0] setupTbl [3] = '{32'h0003_A003, 32'h1003_2003, 32'h2003_2003};

    windowed_watchdog_timer #(.PRESCALE_DIV(4)) u_dut (
        .sys_clk(sys_clk), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .slowTick(slowTick), .debugState(debugState),
        .idleState(idleState), .faultOut(faultOut));
    wdt_far_side #(.SLOW_DIV(2)) u_far (
        .sys_clk(sys_clk), .reset_n(reset_n), .clearSeen(clearSeen),
        .faultOut(faultOut), .slowTick(slowTick),
        .resetAllSeen(resetAllSeen), .resetProcSeen(resetProcSeen));

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    task automatic complete_run;
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : complete_run

    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            complete_run();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : check

    // request held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge sys_clk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1) @(posedge sys_clk);
        rdata = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic restart_wdt(input logic [7:0] key, input logic bit0);
        apb(1'b1, wdt_pkg::OFS_COMMAND, {key, 23'h0, bit0});
    endtask : restart_wdt

    task automatic reset_dut;
        @(posedge sys_clk);
        reset_n   <= 1'b0;
        clearSeen <= 1'b1;
        repeat (2) @(posedge sys_clk);
        reset_n   <= 1'b1;
        clearSeen <= 1'b0;
    endtask : reset_dut

    // bounded wait; a missing fault shows up in the following compare
    task automatic wait_fault(input int maxCycles);
        int n;
        n = 0;
        while (faultOut.faultReset !== 1'b1 && faultOut.faultIrq !== 1'b1
               && n < maxCycles) begin
            @(posedge sys_clk);
            n++;
        end
    endtask : wait_fault

    initial begin
        reset_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h0000_0000; debugState = 1'b0;
        idleState = 1'b0; clearSeen = 1'b0; err_count = 0;
        samples_checked = 0; cycles = 0;
        repeat (10) @(posedge sys_clk);
        reset_n <= 1'b1;
        apb(1'b0, wdt_pkg::OFS_SETUP, 32'h0); check(rdata, 32'h3FFF_2FFF);
        apb(1'b0, wdt_pkg::OFS_FAULT_FLAGS, 32'h0); check(rdata, 32'h0);
        apb(1'b0, 8'h0C, 32'h0); check(rdata, 32'h0);
        apb(1'b1, wdt_pkg::OFS_SETUP, 32'h0003_7003);
        apb(1'b1, wdt_pkg::OFS_SETUP, 32'h0000_0FFF);
        apb(1'b0, wdt_pkg::OFS_SETUP, 32'h0); check(rdata, 32'h0003_7003);
        // restarts every 12 cycles, with one tick between them, keep the counter off zero
        repeat (12) begin
            restart_wdt(wdt_pkg::COMMAND_KEY, 1'b1);
            repeat (9) @(posedge sys_clk);
        end
        check({31'h0, faultOut.faultReset}, 32'h0);
        apb(1'b0, wdt_pkg::OFS_FAULT_FLAGS, 32'h0); check(rdata, 32'h0);
        // wrong key and zero restart bit must not rescue the counter
        repeat (6) begin
            restart_wdt(8'h5A, 1'b1);
            restart_wdt(wdt_pkg::COMMAND_KEY, 1'b0);
        end
        wait_fault(200);
        repeat (2) @(negedge sys_clk);
        check({31'h0, faultOut.faultIrq}, 32'h1);
        check({31'h0, resetProcSeen}, 32'h1);
        check({31'h0, resetAllSeen}, 32'h0);
        apb(1'b0, wdt_pkg::OFS_FAULT_FLAGS, 32'h0); check(rdata, 32'h1);
        // the clear lands at the access edge; look once it has settled
        @(negedge sys_clk);
        check({31'h0, pslverr}, 32'h0);
        check({31'h0, faultOut.faultReset}, 32'h0);
        check({31'h0, faultOut.faultIrq}, 32'h0);
        apb(1'b0, wdt_pkg::OFS_FAULT_FLAGS, 32'h0);
        check({30'h0, rdata[1:0]}, 32'h0);
        // narrow window: an early restart is an error, irq masked
        reset_dut();
        apb(1'b1, wdt_pkg::OFS_SETUP, 32'h000A_2064);
        restart_wdt(8'hA4, 1'b1);
        @(posedge sys_clk);
        apb(1'b0, wdt_pkg::OFS_FAULT_FLAGS, 32'h0); check(rdata, 32'h0);
        restart_wdt(wdt_pkg::COMMAND_KEY, 1'b1);
        wait_fault(20);
        @(negedge sys_clk);
        check({31'h0, faultOut.faultReset}, 32'h1);
        check({31'h0, faultOut.faultIrq}, 32'h0);
        check({31'h0, faultOut.faultResetAll}, 32'h1);
        reset_dut();
        apb(1'b0, wdt_pkg::OFS_FAULT_FLAGS, 32'h0); check(rdata, 32'h0);
        check({31'h0, faultOut.faultReset}, 32'h0);
        apb(1'b1, wdt_pkg::OFS_SETUP, 32'h000A_2064);
        restart_wdt(wdt_pkg::COMMAND_KEY, 1'b1);
        repeat (3) @(posedge sys_clk);
        apb(1'b0, wdt_pkg::OFS_FAULT_FLAGS, 32'h0); check(rdata, 32'h2);
        // disable, debug halt, idle halt in turn
        for (int i = 0; i < 3; i++) begin
            reset_dut();
            apb(1'b1, wdt_pkg::OFS_SETUP, setupTbl[i]);
            debugState <= (i == 1);
            idleState  <= (i == 2);
            repeat (200) @(posedge sys_clk);
            apb(1'b0, wdt_pkg::OFS_FAULT_FLAGS, 32'h0);
            check(rdata, 32'h0);
            debugState <= 1'b0;
            idleState  <= 1'b0;
            if (i != 0) begin
                wait_fault(200);
                apb(1'b0, wdt_pkg::OFS_FAULT_FLAGS, 32'h0);
                check(rdata, 32'h1);
            end
        end
        complete_run();
    end
endmodule : tb_top
